// File: logic/sed_cdb_collect.sv
// Gathers the six command bytes into one block
`timescale 1ns/1ps
`include "sed_consts.svh"
module sed_cdb_collect
    import sed_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  byte_valid,
    input  wire logic  byte_first,
    input  wire logic [7:0] byte_data,
    sed_cdb_if.collector   out
);
    logic [2:0] idx_ff;
    logic [2:0] nxt_idx;
    sed_cdb_t   cdb_ff;
    sed_cdb_t   nxt_cdb;
    logic       done_ff;
    logic       nxt_done;
    logic [2:0] pos;

    always_comb begin
        nxt_idx  = idx_ff;
        nxt_cdb  = cdb_ff;
        nxt_done = 1'b0;
        // A fresh first byte restarts a half-received block
        pos      = byte_first ? 3'd0 : idx_ff;
        if (byte_valid) begin
            nxt_cdb[pos] = byte_data;
            if (pos == 3'(`SED_CDB_LEN - 1)) begin
                nxt_idx  = 3'd0;
                nxt_done = 1'b1;
            end else begin
                nxt_idx  = pos + 3'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            idx_ff  <= 3'd0;
            cdb_ff  <= '0;
            done_ff <= 1'b0;
        end else begin
            idx_ff  <= nxt_idx;
            cdb_ff  <= nxt_cdb;
            done_ff <= nxt_done;
        end
    end

    assign out.cdb  = cdb_ff;
    assign out.done = done_ff;

    property p_done_after_six;
        @(posedge clk) disable iff (rst)
        (byte_valid && (pos == 3'(`SED_CDB_LEN - 1))) |=> done_ff;
    endproperty
    a_done_after_six: assert property (p_done_after_six)
        else $error("block not flagged after last byte");
endmodule : sed_cdb_collect

// File: logic/sed_cdb_if.sv
// Carrier of an assembled command block from collector to decoder
`timescale 1ns/1ps
interface sed_cdb_if;
    import sed_pkg::*;
    sed_cdb_t cdb;
    logic     done;

    modport collector (output cdb, output done);
    modport decoder   (input cdb, input done);
endinterface : sed_cdb_if

// File: logic/sed_consts.svh
// Constants for the security erase command decoder
// Behaviour
// RQ1: Command with vendor opcode in byte 0 overrides the stored default erase setup.
// RQ2: Byte 2 must hold the secondary opcode, otherwise the command is rejected.
// RQ3: Byte 1 carries reserved bits, an erase-option field and a fill-option field.
// RQ4: Fill option: 00 default, 01 no fill, 10 zeros, 11 random pattern.
// RQ5: Erase option: 00 default, 01 erase all, 10 selective by byte 4 mask.
// RQ6: Erase-all erases the whole media whatever the stored configuration holds.
// RQ7: Last byte yields the LINK and FLAG control bits of the command.
// RQ8: Fill from byte 1 bits 1:0, erase from bits 3:2; reserved bits ignored.
`ifndef SED_CONSTS_SVH
`define SED_CONSTS_SVH

// ****************************************************************
// Command layout
// ****************************************************************
`define SED_CDB_LEN       6
`define SED_OPCODE        8'hDF
`define SED_SUBCODE       8'h4D
`define SED_B_OPCODE      0
`define SED_B_OPTIONS     1
`define SED_B_SUBCODE     2
`define SED_B_MASK        4
`define SED_B_CONTROL     5
`define SED_FILL_LSB      0
`define SED_ERASE_LSB     2
`define SED_LINK_BIT      0
`define SED_FLAG_BIT      1

// ****************************************************************
// Reset values and the erase-all mask
// ****************************************************************
`define SED_RST_BYTE      8'h00
`define SED_RST_MASK      8'h00
`define SED_MASK_ALL      8'hFF

`endif

// File: logic/sed_decoder.sv
// Security erase command decoder top
`timescale 1ns/1ps
`include "sed_consts.svh"
module sed_decoder
    import sed_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RESET,
    input  wire logic       CDB_VALID,
    input  wire logic       CDB_FIRST,
    input  wire logic [7:0] CDB_BYTE,
    input  wire logic [1:0] DEF_FILL,
    input  wire logic [1:0] DEF_ERASE,
    input  wire logic [7:0] DEF_MASK,
    output logic            CMD_ACCEPT,
    output logic            CMD_REJECT,
    output logic            CMD_FOREIGN,
    output logic            CMD_OVERRIDE,
    output logic [1:0]      FILL_MODE,
    output logic [1:0]      ERASE_MODE,
    output logic [7:0]      ERASE_MASK,
    output logic            CTRL_LINK,
    output logic            CTRL_FLAG
);
    // ****************************************************************
    // Byte collection
    // ****************************************************************
    sed_cdb_if cdb_bus ();

    sed_cdb_collect u_collect (
        .clk        (CORE_CLK),
        .rst        (RESET),
        .byte_valid (CDB_VALID),
        .byte_first (CDB_FIRST),
        .byte_data  (CDB_BYTE),
        .out        (cdb_bus.collector)
    );

    // ****************************************************************
    // Field helpers
    // ****************************************************************
    function automatic logic [1:0] field2(input logic [7:0] b, input int lsb);
        field2 = b[lsb +: 2];
    endfunction : field2

    // ****************************************************************
    // Decode state
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DECODE,
        ST_REPORT
    } sed_state_t;

    sed_state_t state_ff;
    sed_state_t nxt_state;
    sed_cdb_t   hold_ff;
    sed_cdb_t   nxt_hold;
    logic       accept_ff;
    logic       nxt_accept;
    logic       reject_ff;
    logic       nxt_reject;
    logic       foreign_ff;
    logic       nxt_foreign;
    logic       override_ff;
    logic       nxt_override;
    logic [1:0] fill_ff;
    logic [1:0] nxt_fill;
    logic [1:0] erase_ff;
    logic [1:0] nxt_erase;
    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;
    logic       link_ff;
    logic       nxt_link;
    logic       flag_ff;
    logic       nxt_flag;

    logic [1:0] req_fill;
    logic [1:0] req_erase;
    logic       op_hit;
    logic       sub_hit;

    always_comb begin
        // Reserved bits of byte 1 and all of byte 3 are never looked at
        req_fill  = field2(hold_ff[`SED_B_OPTIONS], `SED_FILL_LSB);   // RQ3 RQ8
        req_erase = field2(hold_ff[`SED_B_OPTIONS], `SED_ERASE_LSB);  // RQ3 RQ8
        op_hit    = (hold_ff[`SED_B_OPCODE] == `SED_OPCODE);          // RQ1
        sub_hit   = (hold_ff[`SED_B_SUBCODE] == `SED_SUBCODE);        // RQ2

        nxt_state    = state_ff;
        nxt_hold     = hold_ff;
        nxt_accept   = 1'b0;
        nxt_reject   = 1'b0;
        nxt_foreign  = 1'b0;
        nxt_override = override_ff;
        nxt_fill     = fill_ff;
        nxt_erase    = erase_ff;
        nxt_mask     = mask_ff;
        nxt_link     = link_ff;
        nxt_flag     = flag_ff;

        case (state_ff)
            ST_IDLE: begin
                if (cdb_bus.done) begin
                    nxt_hold  = cdb_bus.cdb;
                    nxt_state = ST_DECODE;
                end
            end
            ST_DECODE: begin
                nxt_state = ST_REPORT;
                if (!op_hit) begin
                    // Another command: left for the general command path
                    nxt_foreign = 1'b1;
                end else if (!sub_hit || (req_erase == SED_ERASE_RSVD)) begin
                    nxt_reject = 1'b1;                                // RQ2
                end else begin
                    nxt_accept   = 1'b1;
                    nxt_override = 1'b1;                              // RQ1
                    nxt_link     = hold_ff[`SED_B_CONTROL][`SED_LINK_BIT]; // RQ7
                    nxt_flag     = hold_ff[`SED_B_CONTROL][`SED_FLAG_BIT]; // RQ7
                    case (req_fill)                                   // RQ4
                        SED_FILL_DEFAULT: nxt_fill = DEF_FILL;
                        default:          nxt_fill = req_fill;
                    endcase
                    case (req_erase)                                  // RQ5
                        SED_ERASE_ALL: begin
                            // Stored mask is deliberately bypassed
                            nxt_erase = SED_ERASE_ALL;                // RQ6
                            nxt_mask  = `SED_MASK_ALL;                // RQ6
                        end
                        SED_ERASE_SELECT: begin
                            nxt_erase = SED_ERASE_SELECT;
                            nxt_mask  = hold_ff[`SED_B_MASK];
                        end
                        default: begin
                            nxt_erase = DEF_ERASE;
                            nxt_mask  = (DEF_ERASE == SED_ERASE_ALL) ? `SED_MASK_ALL
                                                                     : DEF_MASK;
                        end
                    endcase
                end
            end
            ST_REPORT: begin
                // One idle cycle keeps result pulses apart
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_ff    <= ST_IDLE;
            hold_ff     <= '0;
            accept_ff   <= 1'b0;
            reject_ff   <= 1'b0;
            foreign_ff  <= 1'b0;
            override_ff <= 1'b0;
            fill_ff     <= 2'b00;
            erase_ff    <= 2'b00;
            mask_ff     <= `SED_RST_MASK;
            link_ff     <= 1'b0;
            flag_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            hold_ff     <= nxt_hold;
            accept_ff   <= nxt_accept;
            reject_ff   <= nxt_reject;
            foreign_ff  <= nxt_foreign;
            override_ff <= nxt_override;
            fill_ff     <= nxt_fill;
            erase_ff    <= nxt_erase;
            mask_ff     <= nxt_mask;
            link_ff     <= nxt_link;
            flag_ff     <= nxt_flag;
        end
    end

    assign CMD_ACCEPT   = accept_ff;
    assign CMD_REJECT   = reject_ff;
    assign CMD_FOREIGN  = foreign_ff;
    assign CMD_OVERRIDE = override_ff;
    assign FILL_MODE    = fill_ff;
    assign ERASE_MODE   = erase_ff;
    assign ERASE_MASK   = mask_ff;
    assign CTRL_LINK    = link_ff;
    assign CTRL_FLAG    = flag_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_accept_on_codes;
        @(posedge CORE_CLK) disable iff (RESET)
        (state_ff == ST_DECODE && op_hit && sub_hit && req_erase != 2'b11)
            |=> CMD_ACCEPT && CMD_OVERRIDE;
    endproperty
    a_accept_on_codes: assert property (p_accept_on_codes) // RQ1
        else $error("valid command not accepted");

    property p_reject_bad_sub;
        @(posedge CORE_CLK) disable iff (RESET)
        (state_ff == ST_DECODE && op_hit && !sub_hit) |=> CMD_REJECT && !CMD_ACCEPT;
    endproperty
    a_reject_bad_sub: assert property (p_reject_bad_sub) // RQ2
        else $error("wrong secondary code not rejected");

    property p_fields_pos;
        @(posedge CORE_CLK) disable iff (RESET)
        state_ff == ST_DECODE |-> req_fill == hold_ff[1][1:0] && req_erase == hold_ff[1][3:2];
    endproperty
    a_fields_pos: assert property (p_fields_pos) // RQ8
        else $error("option fields taken from wrong bits");

    property p_fill_decode;
        @(posedge CORE_CLK) disable iff (RESET)
        CMD_ACCEPT |-> FILL_MODE == (($past(req_fill) == 2'b00) ? $past(DEF_FILL)
                                                                : $past(req_fill));
    endproperty
    a_fill_decode: assert property (p_fill_decode) // RQ4
        else $error("fill mode decoded wrongly");

    property p_select_mask;
        @(posedge CORE_CLK) disable iff (RESET)
        (state_ff == ST_DECODE && op_hit && sub_hit && req_erase == 2'b10)
            |=> ERASE_MODE == 2'b10 && ERASE_MASK == $past(hold_ff[4]);
    endproperty
    a_select_mask: assert property (p_select_mask) // RQ5
        else $error("selective erase mask not taken");

    property p_erase_all;
        @(posedge CORE_CLK) disable iff (RESET)
        (state_ff == ST_DECODE && op_hit && sub_hit && req_erase == 2'b01)
            |=> ERASE_MODE == 2'b01 && ERASE_MASK == 8'hFF;
    endproperty
    a_erase_all: assert property (p_erase_all) // RQ6
        else $error("erase all did not cover whole media");

    property p_ctrl_bits;
        @(posedge CORE_CLK) disable iff (RESET)
        CMD_ACCEPT |-> CTRL_LINK == $past(hold_ff[5][0]) && CTRL_FLAG == $past(hold_ff[5][1]);
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) // RQ7
        else $error("control bits not extracted");

    property p_one_result;
        @(posedge CORE_CLK) disable iff (RESET)
        (CMD_ACCEPT || CMD_REJECT || CMD_FOREIGN)
            |-> $onehot({CMD_ACCEPT, CMD_REJECT, CMD_FOREIGN}) ##1 !CMD_ACCEPT && !CMD_REJECT;
    endproperty
    a_one_result: assert property (p_one_result) // RQ2
        else $error("result pulses overlap");

    property p_done_to_result;
        @(posedge CORE_CLK) disable iff (RESET)
        (cdb_bus.done && state_ff == ST_IDLE)
            |-> ##2 (CMD_ACCEPT || CMD_REJECT || CMD_FOREIGN);
    endproperty
    a_done_to_result: assert property (p_done_to_result) // RQ1
        else $error("no result two cycles after block");
endmodule : sed_decoder

// File: logic/sed_pkg.sv
// Types shared by the security erase command decoder
package sed_pkg;
    typedef enum logic [1:0] {
        SED_FILL_DEFAULT,
        SED_FILL_NONE,
        SED_FILL_ZERO,
        SED_FILL_RANDOM
    } sed_fill_t;

    typedef enum logic [1:0] {
        SED_ERASE_DEFAULT,
        SED_ERASE_ALL,
        SED_ERASE_SELECT,
        SED_ERASE_RSVD
    } sed_erase_t;

    typedef logic [5:0][7:0] sed_cdb_t;
endpackage : sed_pkg

// File: test/sed_initiator.sv
// Behavioural initiator that hands command bytes to the decoder
`timescale 1ns/1ps
module sed_initiator
    import sed_pkg::*;
(
    input  wire logic       clk,
    output logic            valid,
    output logic            first,
    output logic [7:0]      data
);
    initial begin
        valid = 1'b0;
        first = 1'b0;
        data  = 8'h00;
    end

    // ****************************************************************
    // Byte sender
    // ****************************************************************
    // Gap above zero gives a slow initiator with idle cycles between bytes
    task automatic send(input sed_cdb_t cdb, input int n, input int gap);
        @(posedge clk);
        #1;
        for (int i = 0; i < n; i++) begin
            valid = 1'b1;
            first = (i == 0);
            data  = cdb[i];
            @(posedge clk);
            #1;
            if (gap > 0 || i == n - 1) begin
                // Released bus must not keep showing the last byte
                valid = 1'b0;
                first = 1'b0;
                data  = ~data;
                // No gap after the last byte: callers time the result from it
                repeat ((i < n - 1) ? gap : 0) begin
                    @(posedge clk);
                    #1;
                end
            end
        end
    endtask : send
endmodule : sed_initiator

// File: test/tb.sv
// Self-checking bench for the security erase command decoder
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    import sed_pkg::*;
    logic       CORE_CLK = 1'b0;
    logic       RESET    = 1'b1;
    logic       CDB_VALID, CDB_FIRST;
    logic [7:0] CDB_BYTE;
    logic [1:0] DEF_FILL  = 2'h2;
    logic [1:0] DEF_ERASE = 2'h2;
    logic [7:0] DEF_MASK  = 8'h0F;
    logic       CMD_ACCEPT, CMD_REJECT, CMD_FOREIGN, CMD_OVERRIDE;
    logic [1:0] FILL_MODE, ERASE_MODE;
    logic [7:0] ERASE_MASK;
    logic       CTRL_LINK, CTRL_FLAG;
    logic [1:0] e_fill, e_erase;
    logic [7:0] e_mask;
    logic       e_link, e_flag, e_ovr;
    int         failures  = 0;
    int         cmp_count = 0;
    int         cycles    = 0;

    always #20 CORE_CLK = ~CORE_CLK;

    sed_initiator sed_initiator_i (.clk(CORE_CLK), .valid(CDB_VALID), .first(CDB_FIRST),
        .data(CDB_BYTE));
    sed_decoder sed_decoder_i (.CORE_CLK(CORE_CLK), .RESET(RESET), .CDB_VALID(CDB_VALID),
        .CDB_FIRST(CDB_FIRST), .CDB_BYTE(CDB_BYTE), .DEF_FILL(DEF_FILL),
        .DEF_ERASE(DEF_ERASE), .DEF_MASK(DEF_MASK), .CMD_ACCEPT(CMD_ACCEPT),
        .CMD_REJECT(CMD_REJECT), .CMD_FOREIGN(CMD_FOREIGN), .CMD_OVERRIDE(CMD_OVERRIDE),
        .FILL_MODE(FILL_MODE), .ERASE_MODE(ERASE_MODE), .ERASE_MASK(ERASE_MASK),
        .CTRL_LINK(CTRL_LINK), .CTRL_FLAG(CTRL_FLAG));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // Whole run needs well under a thousand cycles
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            test_done();
        end
    end

    task automatic check_out(input logic a, input logic r, input logic f);
        `CHK(CMD_ACCEPT, a)
        `CHK(CMD_REJECT, r)
        `CHK(CMD_FOREIGN, f)
        `CHK(CMD_OVERRIDE, e_ovr)
        `CHK(FILL_MODE, e_fill)
        `CHK(ERASE_MODE, e_erase)
        `CHK(ERASE_MASK, e_mask)
        `CHK(CTRL_LINK, e_link)
        `CHK(CTRL_FLAG, e_flag)
    endtask : check_out

    task automatic do_reset();
        RESET = 1'b1;
        repeat (2) @(posedge CORE_CLK);
        #1;
        RESET = 1'b0;
        {e_fill, e_erase, e_mask, e_link, e_flag, e_ovr} = '0;
        check_out(1'b0, 1'b0, 1'b0);
    endtask : do_reset

    task automatic issue(input logic [7:0] op, input logic [7:0] opt, input logic [7:0] sub,
                         input logic [7:0] msk, input logic [7:0] ctl, input int gap);
        logic acc;
        acc = (op == 8'hDF) && (sub == 8'h4D) && (opt[3:2] != 2'h3);
        if (acc) begin
            e_fill  = (opt[1:0] == 2'h0) ? DEF_FILL : opt[1:0];
            e_erase = (opt[3:2] == 2'h0) ? DEF_ERASE : opt[3:2];
            e_mask  = (e_erase == 2'h1) ? 8'hFF : ((opt[3:2] == 2'h2) ? msk : DEF_MASK);
            e_link  = ctl[0];
            e_flag  = ctl[1];
            e_ovr   = 1'b1;
        end
        // Byte 3 carries junk that the decoder must ignore
        sed_initiator_i.send({ctl, msk, 8'h5A, sub, opt, op}, 6, gap);
        // Last byte taken one edge ago; the result pulse stands two edges later
        @(posedge CORE_CLK);
        #1;
        `CHK(CMD_ACCEPT | CMD_REJECT | CMD_FOREIGN, 1'b0)
        @(posedge CORE_CLK);
        #1;
        check_out(acc, (op == 8'hDF) && !acc, op != 8'hDF);
    endtask : issue

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_fill();
        for (int f = 0; f < 4; f++)
            issue(8'hDF, {6'h29, f[1:0]}, 8'h4D, 8'h3C, {6'h35, f[1:0]}, 0);
        $display("test fill done");
    endtask : t_fill

    task automatic t_erase();
        for (int e = 0; e < 3; e++)
            issue(8'hDF, {4'h5, e[1:0], 2'h3}, 8'h4D, 8'hA6, 8'h00, 2);
        DEF_ERASE = 2'h1;
        issue(8'hDF, 8'hF1, 8'h4D, 8'h12, 8'h03, 1);
        $display("test erase done");
    endtask : t_erase

    task automatic t_reject();
        issue(8'hDF, 8'h06, 8'h4C, 8'h77, 8'h01, 0);
        issue(8'hDF, 8'h0E, 8'h4D, 8'h77, 8'h01, 0);
        issue(8'h12, 8'h06, 8'h4D, 8'h77, 8'h01, 0);
        $display("test reject done");
    endtask : t_reject

    task automatic t_realign();
        sed_initiator_i.send({8'hFF, 8'hFF, 8'hFF, 8'h4D, 8'h05, 8'hDF}, 3, 0);
        issue(8'hDF, 8'h0A, 8'h4D, 8'hC3, 8'h02, 0);
        do_reset();
        issue(8'hDF, 8'h09, 8'h4D, 8'h99, 8'h01, 0);
        $display("test realign done");
    endtask : t_realign

    initial begin
        repeat (2) @(posedge CORE_CLK);
        #1;
        RESET = 1'b0;
        {e_fill, e_erase, e_mask, e_link, e_flag, e_ovr} = '0;
        check_out(1'b0, 1'b0, 1'b0);
        t_fill();
        t_erase();
        t_reject();
        t_realign();
        test_done();
    end
endmodule : tb
